// ===== drcagc_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "drcagc_consts.svh"

//////////////////////////////////////////////////////////////////////////////
module drcagc_top #(
	parameter int GAIN_W = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [11:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_write,
	input wire logic bus_read,
	output logic [31:0] bus_rdata,
	// left upper averaging half, kept in the neighbouring bank
	input wire logic [10:0] left_avg_hi_bits,
	// gain samples from the compressor datapath
	input wire logic gain_valid,
	input wire logic [GAIN_W-1:0] gain_cur,
	input wire logic [GAIN_W-1:0] gain_prev,
	// compressor parameters
	output drcagc_pkg::drcagc_coef_s coefs,
	output logic [26:0] smooth_coef,
	output drcagc_pkg::drcagc_smooth_e smooth_state,
	output logic [24:0] hysteresis,
	output logic [GAIN_W-1:0] init_gain,
	output logic param_update,
	// gain control enables
	output logic gainctl_if1_slot0_cap_left_en,
	output logic gainctl_if1_slot0_cap_right_en,
	output logic gainctl_if1_slot1_cap_left_en,
	output logic gainctl_if1_slot1_cap_right_en,
	output logic gainctl_if2_cap_left_en,
	output logic gainctl_if2_cap_right_en,
	output logic gainctl_if2_play_left_en,
	output logic gainctl_if2_play_right_en,
	output logic gainctl_conv_cap_left_en,
	output logic gainctl_conv_cap_right_en
);

	//////////////////////////////////////////////////////////////////////////
	// bus request

	drcagc_pkg::drcagc_bus_s req;

	// one assignment for the whole carrier, so the struct has a single driver
	assign req = {bus_addr, bus_wdata, bus_write, bus_read};

	logic wr_left_lo;
	logic wr_right_hi;
	logic wr_right_lo;
	logic wr_decay_hi;
	logic wr_decay_lo;
	logic wr_attack_hi;
	logic wr_attack_lo;
	logic wr_thresh_hi;
	logic wr_thresh_lo;
	logic wr_slope_hi;
	logic wr_slope_lo;
	logic wr_offset_hi;
	logic wr_offset_lo;
	logic wr_options;
	logic wr_enables;
	logic wr_any;

	assign wr_left_lo = req.write && (req.addr == `DRCAGC_OFF_LEFT_AVG_LO);
	assign wr_right_hi = req.write && (req.addr == `DRCAGC_OFF_RIGHT_AVG_HI);
	assign wr_right_lo = req.write && (req.addr == `DRCAGC_OFF_RIGHT_AVG_LO);
	assign wr_decay_hi = req.write && (req.addr == `DRCAGC_OFF_DECAY_HI);
	assign wr_decay_lo = req.write && (req.addr == `DRCAGC_OFF_DECAY_LO);
	assign wr_attack_hi = req.write && (req.addr == `DRCAGC_OFF_ATTACK_HI);
	assign wr_attack_lo = req.write && (req.addr == `DRCAGC_OFF_ATTACK_LO);
	assign wr_thresh_hi = req.write && (req.addr == `DRCAGC_OFF_THRESH_HI);
	assign wr_thresh_lo = req.write && (req.addr == `DRCAGC_OFF_THRESH_LO);
	assign wr_slope_hi = req.write && (req.addr == `DRCAGC_OFF_SLOPE_HI);
	assign wr_slope_lo = req.write && (req.addr == `DRCAGC_OFF_SLOPE_LO);
	assign wr_offset_hi = req.write && (req.addr == `DRCAGC_OFF_OFFSET_HI);
	assign wr_offset_lo = req.write && (req.addr == `DRCAGC_OFF_OFFSET_LO);
	assign wr_options = req.write && (req.addr == `DRCAGC_OFF_OPTIONS);
	assign wr_enables = req.write && (req.addr == `DRCAGC_OFF_GAINCTL_ENA);

	// the enable register does not touch compressor parameters
	assign wr_any = wr_left_lo | wr_right_hi | wr_right_lo | wr_decay_hi | wr_decay_lo
		| wr_attack_hi | wr_attack_lo | wr_thresh_hi | wr_thresh_lo | wr_slope_hi
		| wr_slope_lo | wr_offset_hi | wr_offset_lo | wr_options;

	//////////////////////////////////////////////////////////////////////////
	// split coefficients

	logic [15:0] left_avg_lo;
	logic [26:0] right_avg;
	logic [26:0] decay;
	logic [26:0] attack;
	logic [31:0] threshold;
	logic [26:0] slope;
	logic [28:0] offset;
	logic [26:0] left_avg;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			left_avg_lo <= `DRCAGC_RST_COEF_LO;
		end else if (wr_left_lo) begin
			left_avg_lo <= req.wdata[15:0];
		end
	end

	// upper half lives outside, so the joined value is re-registered here
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			left_avg <= '0;
		end else begin
			left_avg <= {left_avg_hi_bits, left_avg_lo};
		end
	end

	drcagc_param_reg #(
		.HI_W(`DRCAGC_COEF_HI_W),
		.HI_RESET(`DRCAGC_RST_COEF_HI),
		.LO_RESET(`DRCAGC_RST_COEF_LO)
	) u_right_avg (
		.clock(clock),
		.reset_n(reset_n),
		.wr_hi(wr_right_hi),
		.wr_lo(wr_right_lo),
		.wdata(req.wdata[15:0]),
		.value(right_avg)
	);

	drcagc_param_reg #(
		.HI_W(`DRCAGC_COEF_HI_W),
		.HI_RESET(`DRCAGC_RST_COEF_HI),
		.LO_RESET(`DRCAGC_RST_COEF_LO)
	) u_decay (
		.clock(clock),
		.reset_n(reset_n),
		.wr_hi(wr_decay_hi),
		.wr_lo(wr_decay_lo),
		.wdata(req.wdata[15:0]),
		.value(decay)
	);

	drcagc_param_reg #(
		.HI_W(`DRCAGC_COEF_HI_W),
		.HI_RESET(`DRCAGC_RST_COEF_HI),
		.LO_RESET(`DRCAGC_RST_COEF_LO)
	) u_attack (
		.clock(clock),
		.reset_n(reset_n),
		.wr_hi(wr_attack_hi),
		.wr_lo(wr_attack_lo),
		.wdata(req.wdata[15:0]),
		.value(attack)
	);

	drcagc_param_reg #(
		.HI_W(`DRCAGC_THRESH_HI_W),
		.HI_RESET(`DRCAGC_RST_THRESH_HI),
		.LO_RESET(`DRCAGC_RST_THRESH_LO)
	) u_threshold (
		.clock(clock),
		.reset_n(reset_n),
		.wr_hi(wr_thresh_hi),
		.wr_lo(wr_thresh_lo),
		.wdata(req.wdata[15:0]),
		.value(threshold)
	);

	// slope upper register resets to 0x0780; only its low eleven bits are kept
	drcagc_param_reg #(
		.HI_W(`DRCAGC_COEF_HI_W),
		.HI_RESET(`DRCAGC_RST_SLOPE_HI),
		.LO_RESET(`DRCAGC_RST_COEF_LO)
	) u_slope (
		.clock(clock),
		.reset_n(reset_n),
		.wr_hi(wr_slope_hi),
		.wr_lo(wr_slope_lo),
		.wdata(req.wdata[15:0]),
		.value(slope)
	);

	drcagc_param_reg #(
		.HI_W(`DRCAGC_OFFSET_HI_W),
		.HI_RESET(`DRCAGC_RST_COEF_HI),
		.LO_RESET(`DRCAGC_RST_COEF_LO)
	) u_offset (
		.clock(clock),
		.reset_n(reset_n),
		.wr_hi(wr_offset_hi),
		.wr_lo(wr_offset_lo),
		.wdata(req.wdata[15:0]),
		.value(offset)
	);

	assign coefs = {left_avg, right_avg, decay, attack, threshold, slope, offset};

	//////////////////////////////////////////////////////////////////////////
	// options and enables

	logic [5:0] options;
	logic [9:0] enables;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			options <= `DRCAGC_RST_OPTIONS;
		end else if (wr_options) begin
			options <= req.wdata[`DRCAGC_OPT_GAIN_ZERO_BIT:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			enables <= `DRCAGC_RST_GAINCTL_ENA;
		end else if (wr_enables) begin
			enables <= req.wdata[`DRCAGC_ENA_MSB:`DRCAGC_ENA_LSB];
		end
	end

	// bit 15 of the register lands at enables[9]
	assign gainctl_if1_slot0_cap_left_en = enables[9];
	assign gainctl_if1_slot0_cap_right_en = enables[8];
	assign gainctl_if1_slot1_cap_left_en = enables[7];
	assign gainctl_if1_slot1_cap_right_en = enables[6];
	assign gainctl_if2_cap_left_en = enables[5];
	assign gainctl_if2_cap_right_en = enables[4];
	assign gainctl_if2_play_left_en = enables[3];
	assign gainctl_if2_play_right_en = enables[2];
	assign gainctl_conv_cap_left_en = enables[1];
	assign gainctl_conv_cap_right_en = enables[0];

	//////////////////////////////////////////////////////////////////////////
	// starting gain and hysteresis

	logic [4:0] hyst_code;
	logic [4:0] hyst_eff;
	logic [5:0] hyst_shift;
	logic [24:0] next_hysteresis;

	assign hyst_code = options[`DRCAGC_OPT_HYST_MSB:`DRCAGC_OPT_HYST_LSB];

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			init_gain <= GAIN_W'(1) << `DRCAGC_FRAC_BITS;
		end else if (options[`DRCAGC_OPT_GAIN_ZERO_BIT]) begin
			init_gain <= '0;
		end else begin
			init_gain <= GAIN_W'(1) << `DRCAGC_FRAC_BITS;
		end
	end

	always_comb begin
		hyst_eff = (hyst_code == 5'h00) ? `DRCAGC_HYST_ZERO_ALIAS : hyst_code;
		hyst_shift = 6'(hyst_eff) + 6'(`DRCAGC_FRAC_BITS - `DRCAGC_HYST_EXP_BIAS);
		if (hyst_eff >= `DRCAGC_HYST_UNITY_MIN) begin
			next_hysteresis = 25'(1) << `DRCAGC_FRAC_BITS;
		end else begin
			next_hysteresis = 25'(1) << hyst_shift;
		end
	end

	// registered so the comparator sees a clean value two cycles after the write strobe
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hysteresis <= 25'(1) << (`DRCAGC_FRAC_BITS - `DRCAGC_HYST_EXP_BIAS
				+ int'(`DRCAGC_HYST_ZERO_ALIAS));
		end else begin
			hysteresis <= next_hysteresis;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// smoothing state and coefficient choice

	drcagc_smoother #(
		.GAIN_W(GAIN_W)
	) u_smoother (
		.clock(clock),
		.reset_n(reset_n),
		.gain_valid(gain_valid),
		.gain_cur(gain_cur),
		.gain_prev(gain_prev),
		.hysteresis(hysteresis),
		.state(smooth_state)
	);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			smooth_coef <= {11'(`DRCAGC_RST_COEF_HI), `DRCAGC_RST_COEF_LO};
		end else if (smooth_state == drcagc_pkg::SM_ATTACK) begin
			smooth_coef <= attack;
		end else begin
			smooth_coef <= decay;
		end
	end

	// lets the datapath reload parameters after any write to a parameter register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			param_update <= 1'b0;
		end else begin
			param_update <= wr_any;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read back

	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (req.addr)
			`DRCAGC_OFF_LEFT_AVG_LO: next_rdata = 32'(left_avg_lo);
			`DRCAGC_OFF_RIGHT_AVG_HI: next_rdata = 32'(right_avg[26:16]);
			`DRCAGC_OFF_RIGHT_AVG_LO: next_rdata = 32'(right_avg[15:0]);
			`DRCAGC_OFF_DECAY_HI: next_rdata = 32'(decay[26:16]);
			`DRCAGC_OFF_DECAY_LO: next_rdata = 32'(decay[15:0]);
			`DRCAGC_OFF_ATTACK_HI: next_rdata = 32'(attack[26:16]);
			`DRCAGC_OFF_ATTACK_LO: next_rdata = 32'(attack[15:0]);
			`DRCAGC_OFF_THRESH_HI: next_rdata = 32'(threshold[31:16]);
			`DRCAGC_OFF_THRESH_LO: next_rdata = 32'(threshold[15:0]);
			`DRCAGC_OFF_SLOPE_HI: next_rdata = 32'(slope[26:16]);
			`DRCAGC_OFF_SLOPE_LO: next_rdata = 32'(slope[15:0]);
			`DRCAGC_OFF_OFFSET_HI: next_rdata = 32'(offset[28:16]);
			`DRCAGC_OFF_OFFSET_LO: next_rdata = 32'(offset[15:0]);
			`DRCAGC_OFF_OPTIONS: next_rdata = 32'(options);
			`DRCAGC_OFF_GAINCTL_ENA: next_rdata = 32'(enables) << `DRCAGC_ENA_LSB;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			bus_rdata <= 32'h0000_0000;
		end else if (req.read) begin
			bus_rdata <= next_rdata;
		end else begin
			bus_rdata <= 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

// ===== drcagc_consts.svh
`ifndef DRCAGC_CONSTS_SVH
`define DRCAGC_CONSTS_SVH

// register byte offsets
`define DRCAGC_OFF_LEFT_AVG_LO 12'h490
`define DRCAGC_OFF_RIGHT_AVG_HI 12'h494
`define DRCAGC_OFF_RIGHT_AVG_LO 12'h498
`define DRCAGC_OFF_DECAY_HI 12'h49c
`define DRCAGC_OFF_DECAY_LO 12'h4a0
`define DRCAGC_OFF_ATTACK_HI 12'h4a4
`define DRCAGC_OFF_ATTACK_LO 12'h4a8
`define DRCAGC_OFF_THRESH_HI 12'h4ac
`define DRCAGC_OFF_THRESH_LO 12'h4b0
`define DRCAGC_OFF_SLOPE_HI 12'h4b4
`define DRCAGC_OFF_SLOPE_LO 12'h4b8
`define DRCAGC_OFF_OFFSET_HI 12'h4bc
`define DRCAGC_OFF_OFFSET_LO 12'h4c0
`define DRCAGC_OFF_OPTIONS 12'h4c4
`define DRCAGC_OFF_GAINCTL_ENA 12'h4d0

// reset values
`define DRCAGC_RST_COEF_HI 16'h0100
`define DRCAGC_RST_COEF_LO 16'h0000
`define DRCAGC_RST_THRESH_HI 16'h04fb
`define DRCAGC_RST_THRESH_LO 16'h9ed0
`define DRCAGC_RST_SLOPE_HI 16'h0780
`define DRCAGC_RST_OPTIONS 6'h00
`define DRCAGC_RST_GAINCTL_ENA 10'h000

// field layout
`define DRCAGC_COEF_HI_W 11
`define DRCAGC_THRESH_HI_W 16
`define DRCAGC_OFFSET_HI_W 13
`define DRCAGC_OPT_GAIN_ZERO_BIT 5
`define DRCAGC_OPT_HYST_MSB 4
`define DRCAGC_OPT_HYST_LSB 0
`define DRCAGC_ENA_MSB 15
`define DRCAGC_ENA_LSB 6

// hysteresis decode
`define DRCAGC_FRAC_BITS 24
`define DRCAGC_HYST_EXP_BIAS 20
`define DRCAGC_HYST_ZERO_ALIAS 5'h04
`define DRCAGC_HYST_UNITY_MIN 5'h14

`endif

// ===== drcagc_pkg.sv
`default_nettype none
package drcagc_pkg;

	typedef enum logic [1:0] {
		SM_DECAY = 2'b01,
		SM_ATTACK = 2'b10
	} drcagc_smooth_e;

	typedef struct packed {
		logic [26:0] left_avg;
		logic [26:0] right_avg;
		logic [26:0] decay;
		logic [26:0] attack;
		logic [31:0] threshold;
		logic [26:0] slope;
		logic [28:0] offset;
	} drcagc_coef_s;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic write;
		logic read;
	} drcagc_bus_s;

endpackage
`default_nettype wire

// ===== drcagc_param_reg.sv
`timescale 1ns/1ns
`default_nettype none
// one split coefficient: upper half holds HI_W bits, lower half sixteen
module drcagc_param_reg #(
	parameter int HI_W = 11,
	parameter logic [15:0] HI_RESET = 16'h0100,
	parameter logic [15:0] LO_RESET = 16'h0000
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// write side
	input wire logic wr_hi,
	input wire logic wr_lo,
	input wire logic [15:0] wdata,
	// joined value
	output logic [HI_W+15:0] value
);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			value <= {HI_RESET[HI_W-1:0], LO_RESET};
		end else begin
			// bits above HI_W are dropped, never stored
			if (wr_hi) begin
				value[HI_W+15:16] <= wdata[HI_W-1:0];
			end
			if (wr_lo) begin
				value[15:0] <= wdata;
			end
		end
	end

endmodule
`default_nettype wire

// ===== drcagc_smoother.sv
`timescale 1ns/1ns
`default_nettype none
// decay/attack state of the gain smoothing filter
module drcagc_smoother #(
	parameter int GAIN_W = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// gain samples
	input wire logic gain_valid,
	input wire logic [GAIN_W-1:0] gain_cur,
	input wire logic [GAIN_W-1:0] gain_prev,
	input wire logic [24:0] hysteresis,
	// state
	output drcagc_pkg::drcagc_smooth_e state
);

	logic signed [GAIN_W:0] fall;
	logic signed [GAIN_W:0] rise;
	logic signed [GAIN_W:0] hyst_ext;

	// one extra bit so the difference of two signed gains cannot wrap
	assign fall = $signed({gain_prev[GAIN_W-1], gain_prev}) - $signed({gain_cur[GAIN_W-1], gain_cur});
	assign rise = $signed({gain_cur[GAIN_W-1], gain_cur}) - $signed({gain_prev[GAIN_W-1], gain_prev});
	assign hyst_ext = $signed((GAIN_W+1)'(hysteresis));

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state <= drcagc_pkg::SM_DECAY;
		end else if (gain_valid) begin
			case (state)
				drcagc_pkg::SM_DECAY: begin
					if (fall > hyst_ext) begin
						state <= drcagc_pkg::SM_ATTACK;
					end
				end
				drcagc_pkg::SM_ATTACK: begin
					if (rise > hyst_ext) begin
						state <= drcagc_pkg::SM_DECAY;
					end
				end
				default: begin
					state <= drcagc_pkg::SM_DECAY;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ===== drcagc_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "drcagc_consts.svh"
module drcagc_chk #(
	parameter int GAIN_W = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [11:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_write,
	input wire logic bus_read,
	input wire logic [31:0] bus_rdata,
	// gain samples
	input wire logic gain_valid,
	input wire logic [GAIN_W-1:0] gain_cur,
	input wire logic [GAIN_W-1:0] gain_prev,
	// parameters and enables
	input wire drcagc_pkg::drcagc_coef_s coefs,
	input wire logic [26:0] smooth_coef,
	input wire drcagc_pkg::drcagc_smooth_e smooth_state,
	input wire logic [24:0] hysteresis,
	input wire logic [GAIN_W-1:0] init_gain,
	input wire logic gainctl_if1_slot0_cap_left_en,
	input wire logic gainctl_conv_cap_right_en
);
	localparam logic [GAIN_W-1:0] GAIN_ONE = {{(GAIN_W-25){1'b0}}, 1'b1, 24'h00_0000};
	// one bit of headroom so a full-scale swing cannot wrap the difference
	logic signed [GAIN_W:0] fall, rise, hyst_s;
	assign fall = $signed(gain_prev) - $signed(gain_cur);
	assign rise = $signed(gain_cur) - $signed(gain_prev);
	assign hyst_s = $signed({{(GAIN_W-24){1'b0}}, hysteresis});
	function automatic logic [24:0] hyst_dec(input logic [4:0] n);
		if (n == 5'h00)
			return 25'h100;
		if (n >= 5'h14)
			return 25'h100_0000;
		return 25'h1 << (n + 5'h04);
	endfunction
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	//////////////////////////////////////////////////////////////////////////////
	opt_reserved_a: assert property (
		bus_read && bus_addr == `DRCAGC_OFF_OPTIONS |=> bus_rdata[31:6] == 26'h0
	) else $error("options reserved bits not zero");
	ena_reserved_a: assert property (
		bus_read && bus_addr == `DRCAGC_OFF_GAINCTL_ENA |=> bus_rdata[5:0] == 6'h0
	) else $error("enable reserved bits not zero");
	gain_init_a: assert property (
		bus_write && bus_addr == `DRCAGC_OFF_OPTIONS |-> ##2
		init_gain == ($past(bus_wdata[5], 2) ? '0 : GAIN_ONE)
	) else $error("starting gain wrong");
	hyst_code_a: assert property (
		bus_write && bus_addr == `DRCAGC_OFF_OPTIONS |-> ##2
		hysteresis == hyst_dec($past(bus_wdata[4:0], 2))
	) else $error("hysteresis decode wrong");
	to_attack_a: assert property (
		gain_valid && smooth_state == drcagc_pkg::SM_DECAY && fall > hyst_s
		|=> smooth_state == drcagc_pkg::SM_ATTACK
	) else $error("no switch to attack");
	to_decay_a: assert property (
		gain_valid && smooth_state == drcagc_pkg::SM_ATTACK && rise > hyst_s
		|=> smooth_state == drcagc_pkg::SM_DECAY
	) else $error("no switch to decay");
	state_hold_a: assert property (
		!gain_valid |=> $stable(smooth_state)
	) else $error("state moved without a sample");
	coef_pick_a: assert property (
		smooth_coef == ($past(smooth_state) == drcagc_pkg::SM_ATTACK ?
		$past(coefs.attack) : $past(coefs.decay))
	) else $error("smoothing coefficient mismatch");
	slope_lo_a: assert property (
		bus_write && bus_addr == `DRCAGC_OFF_SLOPE_LO |=> coefs.slope[15:0] == $past(bus_wdata[15:0])
	) else $error("slope low half wrong");
	offset_hi_a: assert property (
		bus_write && bus_addr == `DRCAGC_OFF_OFFSET_HI
		|=> coefs.offset[28:16] == $past(bus_wdata[12:0])
	) else $error("offset high part wrong");
	ena_bits_a: assert property (
		bus_write && bus_addr == `DRCAGC_OFF_GAINCTL_ENA |=> gainctl_if1_slot0_cap_left_en ==
		$past(bus_wdata[15]) && gainctl_conv_cap_right_en == $past(bus_wdata[6])
	) else $error("enable bits wrong");
	cover property (gain_valid && smooth_state == drcagc_pkg::SM_DECAY && fall > hyst_s);
	cover property (gain_valid && smooth_state == drcagc_pkg::SM_ATTACK && rise > hyst_s);
	cover property (bus_write && bus_addr == `DRCAGC_OFF_OPTIONS && bus_wdata[5]);
endmodule
`default_nettype wire

// ===== drcagc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "drcagc_consts.svh"
module drcagc_top_tb;
	typedef struct {logic [11:0] addr; logic [15:0] rst; logic [15:0] mask;} drcagc_row_s;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] bus_addr = 12'h000;
	logic [31:0] bus_wdata = 32'h0000_0000;
	logic bus_write = 1'b0;
	logic bus_read = 1'b0;
	logic [10:0] left_avg_hi_bits = 11'h5a5;
	logic gain_valid = 1'b0;
	logic [31:0] gain_cur = 32'h0000_0000;
	logic [31:0] gain_prev = 32'h0000_0000;
	logic [31:0] bus_rdata, init_gain;
	drcagc_pkg::drcagc_coef_s coefs;
	logic [26:0] smooth_coef;
	drcagc_pkg::drcagc_smooth_e smooth_state;
	logic [24:0] hysteresis;
	logic param_update;
	logic gainctl_if1_slot0_cap_left_en, gainctl_if1_slot0_cap_right_en;
	logic gainctl_if1_slot1_cap_left_en, gainctl_if1_slot1_cap_right_en;
	logic gainctl_if2_cap_left_en, gainctl_if2_cap_right_en;
	logic gainctl_if2_play_left_en, gainctl_if2_play_right_en;
	logic gainctl_conv_cap_left_en, gainctl_conv_cap_right_en;
	logic [9:0] ena_vec;
	int err_total = 0;
	int checks = 0;
	// address, reset value, bits kept; 0x4cc is unmapped
	drcagc_row_s rows [16] = '{'{12'h490, 16'h0000, 16'hffff}, '{12'h494, 16'h0100, 16'h07ff},
		'{12'h498, 16'h0000, 16'hffff}, '{12'h49c, 16'h0100, 16'h07ff},
		'{12'h4a0, 16'h0000, 16'hffff}, '{12'h4a4, 16'h0100, 16'h07ff},
		'{12'h4a8, 16'h0000, 16'hffff}, '{12'h4ac, 16'h04fb, 16'hffff},
		'{12'h4b0, 16'h9ed0, 16'hffff}, '{12'h4b4, 16'h0780, 16'h07ff},
		'{12'h4b8, 16'h0000, 16'hffff}, '{12'h4bc, 16'h0100, 16'h1fff},
		'{12'h4c0, 16'h0000, 16'hffff}, '{12'h4c4, 16'h0000, 16'h003f},
		'{12'h4d0, 16'h0000, 16'hffc0}, '{12'h4cc, 16'h0000, 16'h0000}};
	assign ena_vec = {gainctl_if1_slot0_cap_left_en, gainctl_if1_slot0_cap_right_en,
		gainctl_if1_slot1_cap_left_en, gainctl_if1_slot1_cap_right_en, gainctl_if2_cap_left_en,
		gainctl_if2_cap_right_en, gainctl_if2_play_left_en, gainctl_if2_play_right_en,
		gainctl_conv_cap_left_en, gainctl_conv_cap_right_en};
	always #10 clock = ~clock;
	drcagc_top #(.GAIN_W(32)) uut (.clock, .reset_n, .bus_addr, .bus_wdata, .bus_write,
		.bus_read, .bus_rdata, .left_avg_hi_bits, .gain_valid, .gain_cur, .gain_prev, .coefs,
		.smooth_coef, .smooth_state, .hysteresis, .init_gain, .param_update,
		.gainctl_if1_slot0_cap_left_en, .gainctl_if1_slot0_cap_right_en,
		.gainctl_if1_slot1_cap_left_en, .gainctl_if1_slot1_cap_right_en,
		.gainctl_if2_cap_left_en, .gainctl_if2_cap_right_en, .gainctl_if2_play_left_en,
		.gainctl_if2_play_right_en, .gainctl_conv_cap_left_en, .gainctl_conv_cap_right_en);
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_coefs(input drcagc_pkg::drcagc_coef_s got, exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_write <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clock);
		bus_write <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clock);
		bus_read <= 1'b1;
		bus_addr <= a;
		@(posedge clock);
		bus_read <= 1'b0;
		#1 d = bus_rdata;
	endtask
	// state flips on the sample edge, so it is looked at just after it
	task automatic gstep(input logic [31:0] prev, cur, input drcagc_pkg::drcagc_smooth_e st);
		@(posedge clock);
		gain_valid <= 1'b1;
		gain_prev <= prev;
		gain_cur <= cur;
		@(posedge clock);
		gain_valid <= 1'b0;
		#1 chk_val({30'h0, smooth_state}, {30'h0, st});
	endtask
	function automatic logic [31:0] hexp(input int n);
		if (n == 0)
			return 32'h0000_0100;
		if (n >= 20)
			return 32'h0100_0000;
		return 32'h1 << (n + 4);
	endfunction
	task automatic conclude;
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// bounded run: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		conclude;
	end
	initial begin
		logic [31:0] d;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].addr, d);
			chk_val(d, {16'h0, rows[i].rst});
		end
		chk_coefs(coefs, '{{11'h5a5, 16'h0}, 27'h100_0000, 27'h100_0000, 27'h100_0000,
			32'h04fb_9ed0, 27'h780_0000, 29'h100_0000});
		chk_val(hysteresis, 32'h0000_0100);
		chk_val(init_gain, 32'h0100_0000);
		foreach (rows[i])
			wr(rows[i].addr, 32'hffff_ffff);
		foreach (rows[i]) begin
			rd(rows[i].addr, d);
			chk_val(d, {16'h0, rows[i].mask});
		end
		chk_coefs(coefs, '{left_avg: {11'h5a5, 16'hffff}, default: '1});
		chk_val(ena_vec, 10'h3ff);
		@(posedge clock);
		left_avg_hi_bits <= 11'h2c3;
		repeat (2) @(posedge clock);
		#1 chk_val(coefs.left_avg, {5'h0, 11'h2c3, 16'hffff});
		for (int i = 0; i < 32; i++) begin
			wr(`DRCAGC_OFF_OPTIONS, {26'h0, i[0], i[4:0]});
			@(posedge clock);
			#1 chk_val(hysteresis, hexp(i));
			chk_val(init_gain, i[0] ? 32'h0 : 32'h0100_0000);
		end
		for (int i = 6; i < 16; i++) begin
			wr(`DRCAGC_OFF_GAINCTL_ENA, 32'h1 << i);
			#1 chk_val(ena_vec, 10'h1 << (i - 6));
			chk_val(param_update, 1'b0);
		end
		wr(`DRCAGC_OFF_DECAY_LO, 32'h0000_1111);
		wr(`DRCAGC_OFF_ATTACK_LO, 32'h0000_2222);
		#1 chk_val(param_update, 1'b1);
		wr(`DRCAGC_OFF_OPTIONS, 32'h0000_0005);
		@(posedge clock);
		// a fall equal to the hysteresis must not switch
		gstep(32'h1000_0200, 32'h1000_0000, drcagc_pkg::SM_DECAY);
		gstep(32'h1000_0200, 32'h0fff_ffff, drcagc_pkg::SM_ATTACK);
		@(posedge clock);
		#1 chk_val(smooth_coef, {11'h7ff, 16'h2222});
		@(posedge clock);
		gain_prev <= 32'h0000_0000;
		gain_cur <= 32'h1000_0000;
		repeat (2) @(posedge clock);
		#1 chk_val({30'h0, smooth_state}, {30'h0, drcagc_pkg::SM_ATTACK});
		gstep(32'hffff_fe00, 32'h0000_0001, drcagc_pkg::SM_DECAY);
		@(posedge clock);
		#1 chk_val(smooth_coef, {11'h7ff, 16'h1111});
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		#1 chk_val(ena_vec, 10'h0);
		chk_val(init_gain, 32'h0100_0000);
		chk_val(hysteresis, 32'h0000_0100);
		@(posedge clock);
		reset_n <= 1'b1;
		rd(`DRCAGC_OFF_SLOPE_HI, d);
		chk_val(d, 32'h0000_0780);
		conclude;
	end
endmodule
bind drcagc_top drcagc_chk #(.GAIN_W(GAIN_W)) chk (.clock, .reset_n, .bus_addr, .bus_wdata,
	.bus_write, .bus_read, .bus_rdata, .gain_valid, .gain_cur, .gain_prev, .coefs, .smooth_coef,
	.smooth_state, .hysteresis, .init_gain, .gainctl_if1_slot0_cap_left_en,
	.gainctl_conv_cap_right_en);
`default_nettype wire
